// ===== dtcf_pkg.sv
// package: constants and types for the dual timer common functions block
// Behaviour
// - bit 7 selects transmit or demodulation
// - transmit bit 6 routes combined output
// - demod bit 6 picks port2 or port3
// - port3 event raises external interrupt one
// - bits 5:4 choose AND OR NOR NAND
// - combine field survives stop recovery
// - demod bits 5:4 pick edge types
// - bits 3:2 normal, alternating, force low/high
// - writing 00 ends alternating submode
// - wide output inverse bit 0 until counting
// - demod bits 3:2 set glitch filter width
// - bit 1 sets narrow timer enable transition
// - disabled timer drives inverse initial level, except wide when bits 3:2 are 1x (forced)
// - bit 0 sets wide timer enable transition
// - bit 1 sticky rising flag, write-one clears
// - bit 0 sticky falling flag, write-one clears
package dtcf_pkg;
  localparam logic [11:0] DTCF_IDX_COMMON  = 12'hD01;
  localparam logic [11:0] DTCF_IDX_IRQ_ST  = 12'hD04;
  localparam logic [11:0] DTCF_IDX_IRQ_MK  = 12'hD05;
  localparam logic [11:0] DTCF_IDX_STATUS  = 12'hD06;
  localparam logic [13:0] DTCF_ADDR_COMMON = {DTCF_IDX_COMMON, 2'h0};
  localparam logic [13:0] DTCF_ADDR_IRQ_ST = {DTCF_IDX_IRQ_ST, 2'h0};
  localparam logic [13:0] DTCF_ADDR_IRQ_MK = {DTCF_IDX_IRQ_MK, 2'h0};
  localparam logic [13:0] DTCF_ADDR_STATUS = {DTCF_IDX_STATUS, 2'h0};
  localparam logic [7:0]  DTCF_COMMON_RST  = 8'h00;
  localparam int          DTCF_BIT_MODE    = 7;
  localparam int          DTCF_BIT_SEL     = 6;
  localparam logic [3:0]  DTCF_FILT_SHORT  = 4'h4;
  localparam logic [3:0]  DTCF_FILT_LONG   = 4'h8;
  localparam logic [1:0]  DTCF_EV_RISE     = 2'h1;
  typedef struct packed {
    logic       mode;
    logic       sel;
    logic [1:0] func;
    logic [1:0] sub;
    logic       init8;
    logic       init16;
  } dtcf_common_t;
  typedef struct packed {
    logic narrow_timer_output;
    logic wide_timer_output;
    logic narrow_enable;
    logic wide_enable;
  } dtcf_timer_t;
endpackage

// ===== dtcf_top.sv
// module: common functions logic for the narrow and wide timers
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module dtcf_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [13:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire dtcf_pkg::dtcf_timer_t timers,
  input  wire logic               stop_recovery,
  input  wire logic               interrupt_mask_register_bit2,
  input  wire logic               port2_demod_input_pin,
  input  wire logic               port3_demod_input_pin,
  input  wire logic               port_data_out,
  output logic                    combined_output_pin,
  output logic                    narrow_pin_level,
  output logic                    wide_pin_level,
  output logic                    alternating_active,
  output logic                    demod_input,
  output logic                    external_interrupt_request_one,
  output logic                    irq
);
  import dtcf_pkg::*;

  dtcf_common_t common_reg;
  logic [1:0]   irq_st_reg;
  logic [1:0]   irq_mk_reg;
  logic [1:0]   p2_sync_reg;
  logic [1:0]   p3_sync_reg;
  logic         filt_reg;
  logic [3:0]   filt_cnt_reg;
  logic         filt_prev_reg;
  logic         wide_started_reg;
  logic         wide_force_reg;
  logic         alt_reg;
  logic         raw_in;
  logic         rise_ev;
  logic         fall_ev;
  logic         wr_en;
  logic         wr_common;
  logic         rd_en;
  logic [3:0]   filt_len;
  logic         wide_eff;
  logic         comb;

  function automatic logic hit(input logic [13:0] a);
    hit = (a == DTCF_ADDR_COMMON) || (a == DTCF_ADDR_IRQ_ST) ||
          (a == DTCF_ADDR_IRQ_MK) || (a == DTCF_ADDR_STATUS);
  endfunction

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign wr_common = wr_en && (paddr == DTCF_ADDR_COMMON);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit(paddr);

  // register writes; flag set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      common_reg <= dtcf_common_t'(DTCF_COMMON_RST);
    end else begin
      if (wr_common) begin
        common_reg.mode <= pwdata[DTCF_BIT_MODE];
        common_reg.sel  <= pwdata[DTCF_BIT_SEL];
        common_reg.func <= pwdata[5:4];
        common_reg.sub  <= pwdata[3:2];
        if (pwdata[DTCF_BIT_MODE] == 1'b0) begin
          common_reg.init8  <= pwdata[1];
          common_reg.init16 <= pwdata[0];
        end else begin
          common_reg.init8  <= (common_reg.init8 & ~pwdata[1]) | rise_ev;
          common_reg.init16 <= (common_reg.init16 & ~pwdata[0]) | fall_ev;
        end
      end else if (stop_recovery) begin
        common_reg.mode   <= 1'b0;
        common_reg.sel    <= 1'b0;
        common_reg.sub    <= 2'h0;
        common_reg.init8  <= 1'b0;
        common_reg.init16 <= 1'b0; // func kept
      end else if (common_reg.mode) begin
        common_reg.init8  <= common_reg.init8 | rise_ev;
        common_reg.init16 <= common_reg.init16 | fall_ev;
      end
    end
  end

  // interrupt status, mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg <= 2'h0;
      irq_mk_reg <= 2'h0;
    end else begin
      if (wr_en && paddr == DTCF_ADDR_IRQ_MK) begin
        irq_mk_reg <= pwdata[1:0];
      end
      if (rd_en && paddr == DTCF_ADDR_IRQ_ST) begin
        irq_st_reg <= {rise_ev, fall_ev};
      end else begin
        irq_st_reg <= irq_st_reg | {rise_ev, fall_ev};
      end
    end
  end
  assign irq = |(irq_st_reg & irq_mk_reg);

  always_comb begin
    prdata = 32'h0;
    case (paddr)
      DTCF_ADDR_COMMON: prdata = {24'h0, common_reg};
      DTCF_ADDR_IRQ_ST: prdata = {30'h0, irq_st_reg};
      DTCF_ADDR_IRQ_MK: prdata = {30'h0, irq_mk_reg};
      DTCF_ADDR_STATUS: prdata = {29'h0, alt_reg, demod_input, filt_reg};
      default:          prdata = 32'h0;
    endcase
    if (!rd_en) begin
      prdata = 32'h0;
    end
  end

  // input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p2_sync_reg <= 2'h0;
      p3_sync_reg <= 2'h0;
    end else begin
      p2_sync_reg <= {p2_sync_reg[0], port2_demod_input_pin};
      p3_sync_reg <= {p3_sync_reg[0], port3_demod_input_pin};
    end
  end

  assign raw_in = common_reg.sel ? p3_sync_reg[1] : p2_sync_reg[1];
  assign demod_input = raw_in;
  // port3 pin also raises its external request
  assign external_interrupt_request_one = common_reg.mode && common_reg.sel &&
                                          interrupt_mask_register_bit2 && (rise_ev || fall_ev);

  // glitch filter length
  always_comb begin
    case (common_reg.sub)
      2'h1:    filt_len = DTCF_FILT_SHORT;
      2'h2:    filt_len = DTCF_FILT_LONG;
      default: filt_len = 4'h0;
    endcase
  end

  // glitch filter: input must be stable filt_len clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_reg     <= 1'b0;
      filt_cnt_reg <= 4'h0;
    end else if (raw_in == filt_reg) begin
      filt_cnt_reg <= 4'h0;
    end else if (filt_len == 4'h0 || filt_cnt_reg + 4'h1 >= filt_len) begin
      filt_reg     <= raw_in;
      filt_cnt_reg <= 4'h0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_prev_reg <= 1'b0;
    end else begin
      filt_prev_reg <= filt_reg;
    end
  end

  // edges after filter, only enabled kinds
  assign rise_ev = common_reg.mode && filt_reg && !filt_prev_reg &&
                   (common_reg.func == DTCF_EV_RISE || common_reg.func == 2'h2);
  assign fall_ev = common_reg.mode && !filt_reg && filt_prev_reg &&
                   (common_reg.func == 2'h0 || common_reg.func == 2'h2);

  // wide output start tracking, submode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_started_reg <= 1'b0;
      alt_reg          <= 1'b0;
    end else begin
      if (wr_common && !pwdata[DTCF_BIT_MODE]) begin
        wide_started_reg <= 1'b0;
        alt_reg          <= (pwdata[3:2] == 2'h1);
      end else begin
        if (timers.wide_enable) begin
          wide_started_reg <= 1'b1;
        end
        if (common_reg.mode) begin
          alt_reg <= 1'b0;
        end
      end
    end
  end
  assign alternating_active = alt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_force_reg <= 1'b0;
    end else begin
      wide_force_reg <= common_reg.sub[0];
    end
  end

  // pin levels per timer
  always_comb begin
    narrow_pin_level = timers.narrow_enable ? timers.narrow_timer_output : ~common_reg.init8;
    if (common_reg.sub[1]) begin
      wide_eff = wide_force_reg;
    end else if (!timers.wide_enable || !wide_started_reg) begin
      wide_eff = ~common_reg.init16;
    end else begin
      wide_eff = timers.wide_timer_output;
    end
    wide_pin_level = wide_eff;
  end

  always_comb begin
    case (common_reg.func)
      2'h0:    comb = narrow_pin_level & wide_pin_level;
      2'h1:    comb = narrow_pin_level | wide_pin_level;
      2'h2:    comb = ~(narrow_pin_level | wide_pin_level);
      default: comb = ~(narrow_pin_level & wide_pin_level);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      combined_output_pin <= 1'b0;
    end else begin
      combined_output_pin <= (!common_reg.mode && common_reg.sel) ? comb : port_data_out;
    end
  end

  property p_flag_sticky;
    @(posedge pclk) disable iff (!presetn)
      (common_reg.mode && common_reg.init8 && !(wr_en && paddr == DTCF_ADDR_COMMON) && !stop_recovery)
      |=> common_reg.init8;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("rise flag lost");

  property p_rise_sets;
    @(posedge pclk) disable iff (!presetn)
      (rise_ev && !stop_recovery) |=> common_reg.init8;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise not flagged");

  property p_fall_sets;
    @(posedge pclk) disable iff (!presetn)
      (fall_ev && !stop_recovery) |=> common_reg.init16;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall not flagged");

  property p_func_kept;
    @(posedge pclk) disable iff (!presetn)
      (stop_recovery && !wr_en) |=> $stable(common_reg.func);
  endproperty
  a_func_kept: assert property (p_func_kept) else $error("combine field cleared");

  property p_disabled_level;
    @(posedge pclk) disable iff (!presetn)
      !timers.narrow_enable |-> narrow_pin_level == ~common_reg.init8;
  endproperty
  a_disabled_level: assert property (p_disabled_level) else $error("narrow idle level wrong");

  property p_no_edge_xmit;
    @(posedge pclk) disable iff (!presetn)
      !common_reg.mode |-> !rise_ev && !fall_ev && !external_interrupt_request_one;
  endproperty
  a_no_edge_xmit: assert property (p_no_edge_xmit) else $error("edge in transmit mode");

  property p_pin_route;
    @(posedge pclk) disable iff (!presetn)
      (!common_reg.mode && !common_reg.sel) |=> combined_output_pin == $past(port_data_out);
  endproperty
  a_pin_route: assert property (p_pin_route) else $error("port output not routed");

  property p_alt_end;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == DTCF_ADDR_COMMON && pwdata[7:2] == 6'h0) |=> !alternating_active;
  endproperty
  a_alt_end: assert property (p_alt_end) else $error("alternating not ended");

  property p_alt_start;
    @(posedge pclk) disable iff (!presetn)
      (wr_common && !pwdata[DTCF_BIT_MODE] && pwdata[3:2] == 2'h1) |=> alternating_active;
  endproperty
  a_alt_start: assert property (p_alt_start) else $error("alternating not started");

  property p_mode_write;
    @(posedge pclk) disable iff (!presetn)
      wr_common |=> common_reg.mode == $past(pwdata[DTCF_BIT_MODE]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode bit not written");

  property p_demod_p3;
    @(posedge pclk) disable iff (!presetn)
      (common_reg.sel && $stable(common_reg.sel)) |-> demod_input == $past(p3_sync_reg[0]);
  endproperty
  a_demod_p3: assert property (p_demod_p3) else $error("port3 pin not selected");

  property p_ext_gate;
    @(posedge pclk) disable iff (!presetn)
      external_interrupt_request_one |-> common_reg.mode && common_reg.sel && interrupt_mask_register_bit2;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external request without gating");

  property p_comb_and;
    @(posedge pclk) disable iff (!presetn)
      (!common_reg.mode && common_reg.sel && common_reg.func == 2'h0)
      |=> combined_output_pin == ($past(narrow_pin_level) & $past(wide_pin_level));
  endproperty
  a_comb_and: assert property (p_comb_and) else $error("and combine wrong");

  property p_comb_or;
    @(posedge pclk) disable iff (!presetn)
      (!common_reg.mode && common_reg.sel && common_reg.func == 2'h1)
      |=> combined_output_pin == ($past(narrow_pin_level) | $past(wide_pin_level));
  endproperty
  a_comb_or: assert property (p_comb_or) else $error("or combine wrong");

  property p_comb_nor;
    @(posedge pclk) disable iff (!presetn)
      (!common_reg.mode && common_reg.sel && common_reg.func == 2'h2)
      |=> combined_output_pin == ~($past(narrow_pin_level) | $past(wide_pin_level));
  endproperty
  a_comb_nor: assert property (p_comb_nor) else $error("nor combine wrong");

  property p_comb_nand;
    @(posedge pclk) disable iff (!presetn)
      (!common_reg.mode && common_reg.sel && common_reg.func == 2'h3)
      |=> combined_output_pin == ~($past(narrow_pin_level) & $past(wide_pin_level));
  endproperty
  a_comb_nand: assert property (p_comb_nand) else $error("nand combine wrong");

  property p_edge_none;
    @(posedge pclk) disable iff (!presetn)
      (common_reg.func == 2'h3) |-> !rise_ev && !fall_ev;
  endproperty
  a_edge_none: assert property (p_edge_none) else $error("edge seen with detect off");

  property p_rise_only;
    @(posedge pclk) disable iff (!presetn)
      (common_reg.func == 2'h1) |-> !fall_ev;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("fall seen in rise mode");

  property p_fall_only;
    @(posedge pclk) disable iff (!presetn)
      (common_reg.func == 2'h0) |-> !rise_ev;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("rise seen in fall mode");

  property p_force_low;
    @(posedge pclk) disable iff (!presetn)
      (!common_reg.mode && common_reg.sub == 2'h2 && $past(common_reg.sub) == 2'h2) |-> !wide_pin_level;
  endproperty
  a_force_low: assert property (p_force_low) else $error("wide output not forced low");

  property p_force_high;
    @(posedge pclk) disable iff (!presetn)
      (!common_reg.mode && common_reg.sub == 2'h3 && $past(common_reg.sub) == 2'h3) |-> wide_pin_level;
  endproperty
  a_force_high: assert property (p_force_high) else $error("wide output not forced high");

  property p_wide_idle;
    @(posedge pclk) disable iff (!presetn)
      (!timers.wide_enable && !common_reg.sub[1]) |-> wide_pin_level == ~common_reg.init16;
  endproperty
  a_wide_idle: assert property (p_wide_idle) else $error("wide idle level wrong");

  property p_filt_short;
    @(posedge pclk) disable iff (!presetn)
      (filt_len == DTCF_FILT_SHORT && $stable(filt_len) && $changed(filt_reg))
      |-> $past(raw_in, 1) == filt_reg && $past(raw_in, 2) == filt_reg &&
          $past(raw_in, 3) == filt_reg && $past(raw_in, 4) == filt_reg;
  endproperty
  a_filt_short: assert property (p_filt_short) else $error("short filter passed a glitch");
endmodule

// ===== dtcf_pins.sv
// partner model: drives the two demodulator input pins
`timescale 1ns/1ps
module dtcf_pins (
  input  wire logic pclk,
  output logic      p2,
  output logic      p3
);
  initial begin
    p2 = 1'h0;
    p3 = 1'h0;
  end
  // selected pin high for n cycles, then both low
  task automatic pulse(input logic s, input int n);
    @(posedge pclk);
    if (s)
      p3 <= 1'h1;
    else
      p2 <= 1'h1;
    repeat (n) @(posedge pclk);
    p2 <= 1'h0;
    p3 <= 1'h0;
  endtask
  // selected pin to a level, kept until next call
  task automatic hold(input logic s, input logic v);
    @(posedge pclk);
    if (s)
      p3 <= v;
    else
      p2 <= v;
  endtask
endmodule

// ===== dual_timer_common_functions_tb_top.sv
// testbench: common functions block against an in-bench model
`timescale 1ns/1ps
module dual_timer_common_functions_tb_top;
  import dtcf_pkg::*;
  localparam logic [13:0] CM = DTCF_ADDR_COMMON;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        sr, mk2, pdo, cop, npl, wpl, alt, dmi, ext, irq, p2, p3, rise, fall;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, cf;
  dtcf_timer_t tm;
  int          n_errors, samples_checked, seed, cyc, ecnt, e0, f, r;
  dtcf_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timers(tm), .stop_recovery(sr), .interrupt_mask_register_bit2(mk2),
    .port2_demod_input_pin(p2), .port3_demod_input_pin(p3), .port_data_out(pdo),
    .combined_output_pin(cop), .narrow_pin_level(npl), .wide_pin_level(wpl),
    .alternating_active(alt), .demod_input(dmi), .external_interrupt_request_one(ext), .irq);
  dtcf_pins u_pins (.pclk, .p2, .p3);
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (ext === 1'h1)
      ecnt <= ecnt + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    seed = 65;
    {psel, penable, pwrite, sr, mk2, pdo, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    tm = '0;
    {n_errors, samples_checked, cyc, ecnt} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, CM, 0);
    chk("reset", rd, 32'(DTCF_COMMON_RST));
    apb(0, 14'h3420, 0);
    chk("unmapped", 32'({er, rd != 0}), 32'h2);
    for (f = 0; f < 4; f++) begin
      @(posedge pclk);
      tm <= '0;
      apb(1, CM, 32'h40 | 32'(f << 4));
      repeat (4) begin
        @(posedge pclk);
        r = $random(seed);
        tm <= {r[1:0], 2'h3};
        pdo <= r[2];
        wt(3);
        chk("combined", 32'(cop), 32'(((f[0] ^ f[1]) ? r[1] | r[0] : r[1] & r[0]) ^ f[1]));
        chk("levels", 32'({npl, wpl}), 32'(r[1:0]));
      end
    end
    apb(1, CM, 0);
    for (f = 0; f < 2; f++) begin
      @(posedge pclk);
      pdo <= f[0];
      wt(3);
      chk("port_out", 32'(cop), 32'(f));
    end
    @(posedge pclk);
    tm <= '0;
    for (f = 0; f < 4; f++) begin
      apb(1, CM, 32'(f));
      wt(2);
      chk("idle", 32'({npl, wpl}), 32'(3 - f));
    end
    for (f = 0; f < 3; f++) begin
      apb(1, CM, 32'h04);
      wt(2);
      chk("alt_on", 32'(alt), 1);
      apb(1, CM, f == 0 ? 32'h0 : f == 1 ? 32'h08 : 32'h0D);
      wt(2);
      chk("alt_end", 32'({alt, wpl}), 32'(f != 1));
    end
    apb(1, CM, 32'h77);
    @(posedge pclk);
    sr <= 1'h1;
    @(posedge pclk);
    sr <= 1'h0;
    apb(0, CM, 0);
    chk("stop", rd, 32'h30);
    tm <= '0;
    mk2 <= 1'h1;
    apb(1, DTCF_ADDR_IRQ_MK, 3);
    for (f = 0; f < 18; f++) begin
      cf = 32'h83 | 32'((f % 2) << 6 | (f / 2 % 3) << 4 | (f / 6) << 2);
      rise = f / 2 % 3 != 0;
      fall = f / 2 % 3 != 1;
      apb(1, CM, cf);
      u_pins.pulse(f[0], 2);
      wt(30);
      apb(0, CM, 0);
      chk("glitch", rd, (cf & 32'hFC) | (f < 6 ? 32'({rise, fall}) : 0));
      apb(1, CM, cf);
      apb(0, DTCF_ADDR_IRQ_ST, 0);
      e0 = ecnt;
      u_pins.pulse(f[0], 12);
      wt(30);
      chk("ext_irq", 32'({irq, ecnt != e0}), 32'({1'h1, f[0]}));
      apb(1, DTCF_ADDR_IRQ_MK, 0);
      wt(1);
      chk("masked", 32'(irq), 0);
      apb(1, DTCF_ADDR_IRQ_MK, 3);
      apb(0, CM, 0);
      chk("flags", rd, (cf & 32'hFC) | 32'({rise, fall}));
      apb(0, DTCF_ADDR_IRQ_ST, 0);
      chk("status", rd, 32'({rise, fall}));
      wt(1);
      chk("irq_off", 32'(irq), 0);
      apb(1, CM, (cf & 32'hFC) | 1);
      u_pins.pulse(!f[0], 12);
      wt(30);
      apb(0, CM, 0);
      chk("w1c", rd, (cf & 32'hFC) | 32'({rise, 1'h0}));
    end
    u_pins.hold(1, 1);
    wt(4);
    chk("demod_in", 32'(dmi), 1);
    wt(10);
    apb(0, DTCF_ADDR_STATUS, 0);
    chk("status_reg", rd, 32'h3);
    apb(1, CM, 32'hF3);
    u_pins.hold(1, 0);
    wt(30);
    apb(0, CM, 0);
    chk("no_edge", rd, 32'hF0);
    give_verdict();
  end
endmodule
